//--- hdl/stop_recovery_map.vh
/*
 * Constants for the stop-state recovery controller: register offsets,
 * field positions, reset values, state codes and hold-off counts.
 * Assumes inclusion by its bare name from plain Verilog-2005 design files.
 */
`ifndef STOP_RECOVERY_MAP_VH
`define STOP_RECOVERY_MAP_VH

// Register offsets
`define REG_WDT_CTL 4'h0
`define REG_RST_STAT 4'h1
`define REG_OSC_CTL 4'h2
`define REG_WAKE_EN 4'h3
`define REG_PORT_IN 4'h4
`define REG_STATE 4'h5

// Watchdog control fields
`define WDT_INT_MODE_BIT 0
`define WDT_STOP_BIT 4
`define WDT_TIMEOUT_BIT 5
`define WDT_PIN_RESET_BIT 6

// Reset status fields
`define RST_STOP_BIT 4

// Oscillator control fields and values
`define OSC_IPO_EN_BIT 0
`define OSC_XTAL_EN_BIT 1
`define OSC_SEL_LSB 2
`define OSC_SEL_IPO 2'h0
`define OSC_CTL_RESET 8'h01
`define OSC_CTL_RECOVERED 8'h01

// Reset vector location, high byte first
`define VEC_ADDR_HI 16'h0002
`define VEC_ADDR_LO 16'h0003

// Hold-off counts in internal oscillator cycles
`define HOLD_IPO_CYCLES 13'h0042
`define HOLD_XTAL_CYCLES 13'h1388

// Least wake pulse, system clock cycles
`define MIN_WAKE_CYCLES 3'h3

// Sequencer states
`define ST_RUN 3'h0
`define ST_STOP 3'h1
`define ST_FILT 3'h2
`define ST_HOLD 3'h3
`define ST_VEC_HI 3'h4
`define ST_VEC_LO 3'h5
`define ST_VEC_END 3'h6
`define ST_SYSRST 3'h7

`endif

//--- hdl/pin_sync.v
/*
 * Two-flop synchroniser bank with a third stage for edge detection.
 * Assumes asynchronous inputs; only the second and third stages are read.
 */
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 8,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire sys_clk,
  input wire resetn,
  input wire clk_en,
  input wire [W-1:0] pin_in,
  output wire [W-1:0] level,
  output wire [W-1:0] change,
  output wire [W-1:0] rise
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  genvar i;

  // Per-bit stages; first flop feeds only the second
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          s1_q[i] <= RST_VAL[i];
          s2_q[i] <= RST_VAL[i];
          s3_q[i] <= RST_VAL[i];
        end else if (clk_en) begin
          s1_q[i] <= pin_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
        end
      end
      assign change[i] = s2_q[i] ^ s3_q[i];
      assign rise[i] = s2_q[i] & ~s3_q[i];
    end
  endgenerate

  assign level = s2_q;
endmodule

//--- hdl/stop_mode_recovery_ctrl.v
/*
 * Stop-state entry and recovery sequencer with its small register file.
 * Assumes CPU strobes on sys_clk, program memory answering one cycle after
 * a read, and pins plus the internal oscillator arriving asynchronously.
 * Software must rewrite oscillator control after every recovery.
 */
`timescale 1ns/1ps
`include "stop_recovery_map.vh"
module stop_mode_recovery_ctrl #(
  parameter [12:0] XTAL_HOLD_CYCLES = `HOLD_XTAL_CYCLES
) (
  input wire sys_clk,
  input wire resetn,
  input wire clk_en,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata_q,
  input wire stop_instr,
  input wire wdt_timeout,
  input wire [7:0] wake_pin,
  input wire ext_reset_n,
  input wire debug_line,
  input wire internal_rc_oscillator,
  input wire [7:0] prog_data,
  output reg [15:0] prog_addr_q,
  output reg prog_rd_q,
  output reg [15:0] pc_q,
  output reg pc_load_q,
  output reg cpu_reset_q,
  output reg sys_reset_q,
  output reg stopped_q,
  output reg wdt_irq_q,
  output reg [7:0] pin_irq_q,
  output reg [7:0] port_input_data_q,
  output reg ipo_en_q,
  output reg [1:0] clk_sel_q
);
  wire [7:0] pin_level;
  wire [7:0] pin_change;
  wire [2:0] misc_level;
  wire [2:0] misc_rise;
  wire ipo_edge;
  wire ext_rst_low;
  wire debug_low;
  wire [7:0] wake_hit;
  wire [12:0] hold_limit;
  wire wr_wdt;
  wire wr_rst;
  wire wr_osc;
  wire wr_wake_en;
  wire wake_taken;
  wire [7:0] wdt_flag_set;
  wire [7:0] rst_flag_set;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [7:0] watchdog_control_reg_q;
  reg [7:0] reset_status_reg_q;
  reg [7:0] oscillator_control_reg_q;
  reg [7:0] wake_en_q;
  reg [7:0] wake_mask_q;
  reg [7:0] wake_base_q;
  reg [2:0] filt_cnt_q;
  reg [12:0] hold_cnt_q;
  reg xtal_hold_q;
  reg [7:0] vec_hi_q;

  // Pins and oscillator all arrive from outside the clock domain
  pin_sync #(.W(8), .RST_VAL(8'h00)) u_wake_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .pin_in(wake_pin),
    .level(pin_level),
    .change(pin_change),
    .rise()
  );

  // Reset and debug lines idle high, so sync resets to one
  pin_sync #(.W(3), .RST_VAL(3'h6)) u_misc_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .pin_in({ext_reset_n, debug_line, internal_rc_oscillator}),
    .level(misc_level),
    .change(),
    .rise(misc_rise)
  );

  assign ipo_edge = misc_rise[0];
  assign debug_low = ~misc_level[1];
  assign ext_rst_low = ~misc_level[2];
  assign wake_hit = pin_change & wake_en_q;
  assign hold_limit = xtal_hold_q ? XTAL_HOLD_CYCLES : `HOLD_IPO_CYCLES;
  assign wr_wdt = wr_stb && (addr == `REG_WDT_CTL);
  assign wr_rst = wr_stb && (addr == `REG_RST_STAT);

  // Clear on write-one; a hardware set in the same cycle wins
  function [7:0] flag_next;
    input [7:0] cur;
    input [7:0] clr;
    input [7:0] set;
    begin
      flag_next = (cur & ~clr) | set;
    end
  endfunction

  // Stop proper plus the pulse filter; both count as being in stop
  function in_stop;
    input [2:0] st;
    begin
      in_stop = (st == `ST_STOP) || (st == `ST_FILT);
    end
  endfunction

  // States that keep the CPU in reset; the load cycle is included so the
  // CPU never runs one cycle from a stale program counter
  function holds_cpu;
    input [2:0] st;
    begin
      holds_cpu = (st == `ST_HOLD) || (st == `ST_VEC_HI) || (st == `ST_VEC_LO) ||
        (st == `ST_VEC_END) || (st == `ST_SYSRST);
    end
  endfunction

  // Register strobes decoded once
  assign wr_osc = wr_stb && (addr == `REG_OSC_CTL);
  assign wr_wake_en = wr_stb && (addr == `REG_WAKE_EN);
  assign wake_taken = in_stop(state_q) && (state_d == `ST_HOLD);
  assign wdt_flag_set = {1'b0, (state_q == `ST_SYSRST) && ext_rst_low,
    in_stop(state_q) && wdt_timeout && !ext_rst_low && !debug_low,
    state_q == `ST_VEC_END, 4'h0};
  assign rst_flag_set = {3'h0, (state_q == `ST_FILT) && (state_d == `ST_STOP), 4'h0};

  // Next-state logic for the recovery sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      `ST_RUN: begin
        if (ext_rst_low) begin
          state_d = `ST_SYSRST;
        end else if (stop_instr) begin
          state_d = `ST_STOP;
        end
      end
      `ST_STOP: begin
        if (ext_rst_low) begin
          state_d = `ST_SYSRST;
        end else if (debug_low) begin
          state_d = `ST_SYSRST;
        end else if (wdt_timeout) begin
          state_d = `ST_HOLD;
        end else if (wake_hit != 8'h00) begin
          state_d = `ST_FILT;
        end
      end
      `ST_FILT: begin
        if (ext_rst_low || debug_low) begin
          state_d = `ST_SYSRST;
        end else if (wdt_timeout) begin
          state_d = `ST_HOLD;
        end else if ((pin_level & wake_mask_q) == wake_base_q) begin
          state_d = `ST_STOP;
        end else if (filt_cnt_q == `MIN_WAKE_CYCLES - 3'h1) begin
          state_d = `ST_HOLD;
        end
      end
      `ST_HOLD: begin
        if (ipo_edge && (hold_cnt_q == hold_limit - 13'h0001)) begin
          state_d = `ST_VEC_HI;
        end
      end
      `ST_VEC_HI: begin
        state_d = `ST_VEC_LO;
      end
      `ST_VEC_LO: begin
        state_d = `ST_VEC_END;
      end
      `ST_VEC_END: begin
        state_d = `ST_RUN;
      end
      `ST_SYSRST: begin
        if (!ext_rst_low && !debug_low) begin
          state_d = `ST_RUN;
        end
      end
      default: begin
        state_d = `ST_RUN;
      end
    endcase
  end

  // Sequencer registers and the outputs that follow the state
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= `ST_RUN;
      wake_mask_q <= 8'h00;
      wake_base_q <= 8'h00;
      vec_hi_q <= 8'h00;
      prog_addr_q <= 16'h0000;
      prog_rd_q <= 1'b0;
      pc_q <= 16'h0000;
      pc_load_q <= 1'b0;
      cpu_reset_q <= 1'b0;
      sys_reset_q <= 1'b0;
      stopped_q <= 1'b0;
      wdt_irq_q <= 1'b0;
      pin_irq_q <= 8'h00;
      port_input_data_q <= 8'h00;
    end else if (clk_en) begin
      state_q <= state_d;
      prog_rd_q <= 1'b0;
      pc_load_q <= 1'b0;
      pin_irq_q <= 8'h00;
      wdt_irq_q <= 1'b0;
      stopped_q <= in_stop(state_d);
      sys_reset_q <= (state_d == `ST_SYSRST);
      // CPU held through hold-off, fetch and load
      cpu_reset_q <= holds_cpu(state_d);
      if (state_q == `ST_RUN) begin
        pin_irq_q <= (pin_level ^ port_input_data_q) & wake_en_q;
        port_input_data_q <= pin_level;
      end
      // Remember which pins moved and their old level
      if (state_q == `ST_STOP && wake_hit != 8'h00) begin
        wake_mask_q <= wake_hit;
        wake_base_q <= ~pin_level & wake_hit;
      end
      // vector fetch, high byte at the lower address
      if (state_d == `ST_VEC_HI) begin
        prog_addr_q <= `VEC_ADDR_HI;
        prog_rd_q <= 1'b1;
        // capture only the level still present
        pin_irq_q <= (pin_level ^ port_input_data_q) & wake_en_q;
        port_input_data_q <= pin_level;
      end
      if (state_q == `ST_VEC_HI) begin
        prog_addr_q <= `VEC_ADDR_LO;
        prog_rd_q <= 1'b1;
      end
      if (state_q == `ST_VEC_LO) begin
        vec_hi_q <= prog_data;
      end
      if (state_q == `ST_VEC_END) begin
        pc_q <= {vec_hi_q, prog_data};
        pc_load_q <= 1'b1;
        wdt_irq_q <= watchdog_control_reg_q[`WDT_TIMEOUT_BIT] &
          watchdog_control_reg_q[`WDT_INT_MODE_BIT];
      end
    end
  end

  // Pulse filter and hold-off counters, kept apart from the sequencer
  // so the long hold-off count stays a simple counter of its own
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      filt_cnt_q <= 3'h0;
      hold_cnt_q <= 13'h0000;
      xtal_hold_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == `ST_STOP) begin
        filt_cnt_q <= 3'h0;
      end else if (state_q == `ST_FILT) begin
        filt_cnt_q <= filt_cnt_q + 3'h1;
      end
      if (wake_taken) begin
        hold_cnt_q <= 13'h0000;
        xtal_hold_q <= oscillator_control_reg_q[`OSC_XTAL_EN_BIT];
      end else if (state_q == `ST_HOLD && ipo_edge) begin
        hold_cnt_q <= hold_cnt_q + 13'h0001;
      end
    end
  end

  // Register file and its hardware-set flags
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_control_reg_q <= 8'h00;
      reset_status_reg_q <= 8'h00;
      oscillator_control_reg_q <= `OSC_CTL_RESET;
      wake_en_q <= 8'h00;
      ipo_en_q <= 1'b1;
      clk_sel_q <= `OSC_SEL_IPO;
    end else if (clk_en) begin
      watchdog_control_reg_q <= flag_next(watchdog_control_reg_q,
        wr_wdt ? (wdata & 8'h70) : 8'h00, wdt_flag_set);
      if (wr_wdt) begin
        watchdog_control_reg_q[`WDT_INT_MODE_BIT] <= wdata[`WDT_INT_MODE_BIT];
      end
      reset_status_reg_q <= flag_next(reset_status_reg_q,
        wr_rst ? (wdata & 8'h10) : 8'h00, rst_flag_set);
      // recovery reloads oscillator control; the watchdog stop flag is set at vector end
      if (wake_taken) begin
        oscillator_control_reg_q <= `OSC_CTL_RECOVERED;
      end else if (state_d == `ST_SYSRST) begin
        oscillator_control_reg_q <= `OSC_CTL_RESET;
      end else if (wr_osc) begin
        oscillator_control_reg_q <= wdata;
      end
      if (wr_wake_en) begin
        wake_en_q <= wdata;
      end
      // Enable and select lag the register by one cycle
      ipo_en_q <= oscillator_control_reg_q[`OSC_IPO_EN_BIT];
      clk_sel_q <= oscillator_control_reg_q[`OSC_SEL_LSB+1:`OSC_SEL_LSB];
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= 8'h00;
      if (rd_stb) begin
        case (addr)
          `REG_WDT_CTL: rdata_q <= watchdog_control_reg_q;
          `REG_RST_STAT: rdata_q <= reset_status_reg_q;
          `REG_OSC_CTL: rdata_q <= oscillator_control_reg_q;
          `REG_WAKE_EN: rdata_q <= wake_en_q;
          `REG_PORT_IN: rdata_q <= port_input_data_q;
          `REG_STATE: rdata_q <= {5'h00, state_q};
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end
endmodule

//--- test/wake_src_model.sv
/* Far-side model: wake pins, reset and debug lines, free oscillator and
   program memory holding the restart vector. Assumes tb moves the pins. */
`timescale 1ns/1ps
module wake_src_model (
  input wire sys_clk,
  input wire [15:0] prog_addr_q,
  input wire prog_rd_q,
  output reg [7:0] prog_data,
  output reg internal_rc_oscillator,
  output reg [7:0] wake_pin,
  output reg ext_reset_n,
  output reg debug_line
);
  // Pulled-up lines idle high; odd offset keeps edges off sys_clk
  initial begin
    prog_data = 8'h00;
    wake_pin = 8'h00;
    ext_reset_n = 1'b1;
    debug_line = 1'b1;
    internal_rc_oscillator = 1'b0;
    #37;
    forever #150 internal_rc_oscillator = ~internal_rc_oscillator;
  end
  always @(posedge sys_clk) begin
    if (prog_rd_q)
      prog_data <= (prog_addr_q == 16'h0003) ? 8'h34 : 8'h12;
    else
      prog_data <= ~prog_data; // Unread cycles invert the last byte, so stale data keeps changing
  end
endmodule

//--- test/recovery_props.sv
/* Port checks on the stop recovery sequencer.
   Assumes bind onto the controller, one clock, clk_en held high. */
`timescale 1ns/1ps
module recovery_props (
  input wire sys_clk,
  input wire resetn,
  input wire stop_instr,
  input wire wdt_timeout,
  input wire ext_reset_n,
  input wire [7:0] prog_data,
  input wire [15:0] prog_addr_q,
  input wire prog_rd_q,
  input wire [15:0] pc_q,
  input wire pc_load_q,
  input wire cpu_reset_q,
  input wire sys_reset_q,
  input wire stopped_q,
  input wire wdt_irq_q,
  input wire [7:0] pin_irq_q
);
  reg rd_d_q;
  reg [15:0] a_d_q;
  reg [7:0] hi_q;
  reg [7:0] lo_q;
  // Mirror vector bytes as memory hands them over
  always @(posedge sys_clk) begin
    rd_d_q <= prog_rd_q;
    a_d_q <= prog_addr_q;
    if (rd_d_q && a_d_q == 16'h0002)
      hi_q <= prog_data;
    if (rd_d_q && a_d_q == 16'h0003)
      lo_q <= prog_data;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_stop_entry: assert property (
    stop_instr && !stopped_q && !cpu_reset_q && !sys_reset_q |-> ##2 stopped_q)
    else $error("stop not entered");
  a_run_ignores: assert property (
    wdt_timeout && !stopped_q && !cpu_reset_q && !sys_reset_q && !$past(stop_instr) |=> !cpu_reset_q)
    else $error("wake taken outside stop");
  a_dog_wakes: assert property (stopped_q && wdt_timeout |=> cpu_reset_q)
    else $error("time-out did not wake");
  a_reset_held: assert property (prog_rd_q |-> cpu_reset_q && !stopped_q)
    else $error("cpu left reset early");
  a_vec_order: assert property (
    prog_rd_q && prog_addr_q == 16'h0002 |=> prog_rd_q && prog_addr_q == 16'h0003)
    else $error("vector fetch order");
  a_vec_to_load: assert property (prog_rd_q && prog_addr_q == 16'h0003 |-> ##[1:3] pc_load_q)
    else $error("no pc load after fetch");
  a_pc_vector: assert property (pc_load_q |-> pc_q == {hi_q, lo_q})
    else $error("pc not the vector");
  a_load_release: assert property (pc_load_q |-> !cpu_reset_q && $past(cpu_reset_q))
    else $error("reset not released at load");
  a_irq_at_load: assert property (wdt_irq_q |-> pc_load_q)
    else $error("interrupt off the load");
  a_pin_sysrst: assert property (!ext_reset_n [*6] |-> sys_reset_q)
    else $error("reset pin ignored");
  c_dog_irq: cover property (pc_load_q && wdt_irq_q);
  c_sysrst: cover property ($rose(sys_reset_q));
  c_pin_irq: cover property (pin_irq_q != 8'h00);
endmodule
bind stop_mode_recovery_ctrl recovery_props i_props (
  .sys_clk, .resetn, .stop_instr, .wdt_timeout, .ext_reset_n, .prog_data, .prog_addr_q,
  .prog_rd_q, .pc_q, .pc_load_q, .cpu_reset_q, .sys_reset_q, .stopped_q, .wdt_irq_q, .pin_irq_q);

//--- test/tb.sv
/* Bench: wake sources, hold-off length, vector, flags, system resets.
   Assumes the source model and the bound checker. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t %h %h", $time, g, e); end end
`define WT(c) begin k = 0; while (!(c) && k < 5000) begin @(posedge sys_clk) #1; k++; end if (!(c)) error_cnt++; end
module tb;
  localparam [12:0] XH = 13'h8; // Short crystal hold keeps the run brief
  reg sys_clk = 1'b0;
  reg resetn = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg wr_stb = 1'b0;
  reg rd_stb = 1'b0;
  reg stop_instr = 1'b0;
  reg wdt_timeout = 1'b0;
  wire [7:0] rdata_q, prog_data, wake_pin, pin_irq_q, port_input_data_q;
  wire [15:0] prog_addr_q, pc_q;
  wire [1:0] clk_sel_q;
  wire ext_reset_n, debug_line, internal_rc_oscillator, prog_rd_q, pc_load_q;
  wire cpu_reset_q, sys_reset_q, stopped_q, wdt_irq_q, ipo_en_q;
  int error_cnt = 0;
  int n_tests = 0;
  int k;
  reg [7:0] d;
  reg irq;
  reg irq_seen;
  stop_mode_recovery_ctrl #(.XTAL_HOLD_CYCLES(XH)) i_dut (
    .sys_clk, .resetn, .clk_en(1'b1), .addr, .wdata, .wr_stb, .rd_stb, .rdata_q, .stop_instr,
    .wdt_timeout, .wake_pin, .ext_reset_n, .debug_line, .internal_rc_oscillator, .prog_data,
    .prog_addr_q, .prog_rd_q, .pc_q, .pc_load_q, .cpu_reset_q, .sys_reset_q, .stopped_q,
    .wdt_irq_q, .pin_irq_q, .port_input_data_q, .ipo_en_q, .clk_sel_q);
  wake_src_model i_src (
    .sys_clk, .prog_addr_q, .prog_rd_q, .prog_data, .internal_rc_oscillator, .wake_pin,
    .ext_reset_n, .debug_line);
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // Catch one-cycle pin interrupt pulses
  always @(posedge sys_clk) begin
    if (pin_irq_q[0])
      irq_seen <= 1'b1;
  end
  task wr(input [3:0] a, input [7:0] v);
    begin
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge sys_clk) #1;
      wr_stb <= 1'b0;
      @(posedge sys_clk) #1;
    end
  endtask
  task rd(input [3:0] a);
    begin
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk) #1;
      rd_stb <= 1'b0;
      d = rdata_q;
      @(posedge sys_clk) #1;
    end
  endtask
  task go_stop;
    begin
      stop_instr <= 1'b1;
      @(posedge sys_clk) #1;
      stop_instr <= 1'b0;
      `WT(stopped_q)
      repeat (10) @(posedge sys_clk) #1;
      `CHK(stopped_q, 1'b1)
    end
  endtask
  // Hold-off measured in oscillator periods of three system clocks
  task recover(input int n);
    int c;
    begin
      `WT(cpu_reset_q)
      c = 0;
      while (!prog_rd_q && c < 5000) begin
        @(posedge sys_clk) #1;
        c++;
      end
      // First counted oscillator edge lands one to three clocks after entry
      `CHK(c >= 3 * n - 2 && c <= 3 * n + 2, 1'b1)
      `WT(pc_load_q)
      `CHK(pc_q, 16'h1234)
      `CHK({ipo_en_q, clk_sel_q}, 3'h4)
      irq = wdt_irq_q;
      repeat (3) @(posedge sys_clk) #1;
    end
  endtask
  task t_reset;
    begin
      rd(4'h2);
      `CHK(d, 8'h01)
      rd(4'hf);
      `CHK(d, 8'h00)
      wr(4'h3, 8'h01);
      wdt_timeout <= 1'b1;
      i_src.wake_pin <= 8'h01;
      @(posedge sys_clk) #1;
      wdt_timeout <= 1'b0;
      repeat (20) @(posedge sys_clk) #1;
      `CHK(cpu_reset_q, 1'b0)
      rd(4'h5);
      `CHK(d, 8'h00)
      $display("reset done");
    end
  endtask
  task t_dog(input [7:0] osc_v, input bit m, input int n);
    begin
      wr(4'h0, {7'h00, m});
      wr(4'h2, osc_v);
      wr(4'h3, 8'h5a);
      go_stop;
      wdt_timeout <= 1'b1;
      @(posedge sys_clk) #1;
      wdt_timeout <= 1'b0;
      recover(n);
      `CHK(irq, m)
      rd(4'h0);
      `CHK(d, {7'h18, m})
      rd(4'h2);
      `CHK(d, 8'h01)
      rd(4'h3);
      `CHK(d, 8'h5a)
      wr(4'h0, 8'h30);
      $display("time-out wake done");
    end
  endtask
  task t_pin(input bit keep);
    reg v;
    begin
      wr(4'h3, 8'h01);
      v = port_input_data_q[0];
      go_stop;
      irq_seen = 1'b0;
      i_src.wake_pin <= {7'h00, ~v};
      `WT(cpu_reset_q)
      if (!keep)
        i_src.wake_pin <= {7'h00, v};
      recover(66);
      `CHK(port_input_data_q[0], keep ? ~v : v)
      `CHK(irq_seen, keep)
      $display("pin wake done");
    end
  endtask
  task t_short;
    reg v;
    begin
      v = port_input_data_q[0];
      go_stop;
      i_src.wake_pin <= {7'h00, ~v};
      @(posedge sys_clk) #1;
      i_src.wake_pin <= {7'h00, v};
      repeat (20) @(posedge sys_clk) #1;
      `CHK(stopped_q, 1'b1)
      `CHK(cpu_reset_q, 1'b0)
      rd(4'h1);
      `CHK(d, 8'h10)
      $display("short pulse done");
    end
  endtask
  task t_sys(input bit pin_rst);
    begin
      if (!stopped_q)
        go_stop;
      if (pin_rst)
        i_src.ext_reset_n <= 1'b0;
      else
        i_src.debug_line <= 1'b0;
      repeat (8) @(posedge sys_clk) #1;
      `CHK({sys_reset_q, pc_load_q}, 2'h2)
      i_src.ext_reset_n <= 1'b1;
      i_src.debug_line <= 1'b1;
      `WT(!sys_reset_q)
      repeat (3) @(posedge sys_clk) #1;
      rd(4'h0);
      `CHK(d[6], pin_rst)
      $display("system reset done");
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    irq_seen = 1'b0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk) #1;
    t_reset;
    t_dog(8'h0d, 1'b0, 66);
    t_dog(8'h0f, 1'b1, XH);
    t_pin(1'b1);
    t_pin(1'b1);
    t_pin(1'b0);
    t_short;
    t_sys(1'b0);
    t_sys(1'b1);
    conclude;
  end
  // Whole run needs about 1100 cycles; allow over fifteen times that
  initial begin
    #2000000;
    error_cnt++;
    conclude;
  end
endmodule
